/* File: bench/mcu_model.sv */
// microcontroller model: answers each wake-up rise with watchdog pulses
`timescale 1ns/100ps
module mcu_model (
  input wire logic clk, // clock
  input wire logic wakeup, // wake-up in
  input wire logic [1:0] mode, // 0 silent, 1 one pulse, 2 two pulses
  output logic watchdog_input // watchdog pin, idle high
);
  logic wake_d; // last wake level
  int k; // edge count
  // pulses last 3 cycles so the pin filter always accepts them
  initial
  begin
    watchdog_input = 1'b1;
    wake_d = 1'b0;
    forever
    begin
      @(negedge clk);
      if (wakeup && !wake_d)
        for (k = 0; k < 2 * mode; k++)
        begin
          repeat (3) @(negedge clk);
          watchdog_input = ~watchdog_input;
        end
      wake_d = wakeup;
    end
  end
endmodule

/* File: bench/testbench.sv */
// testbench: supervisor against a microcontroller model
`timescale 1ns/100ps
module testbench;
  localparam int HALF = 20; // short half period keeps the run brief
  localparam int RST = 5; // reset delay
  localparam int REL = 10; // release to first rise
  typedef struct {logic [1:0] m; int off; logic w; logic r;} row_t;
  logic clk = 1'b0, reset = 1'b1, in_regulation = 1'b0; // inputs
  logic [1:0] mode = 2'h1; // model answer
  logic watchdog_input, wakeup, reset_out_n; // pins
  int n_fail = 0, checked = 0, i, t, p; // counters
  // mode, cycles after a rise, wake-up, reset
  row_t rows [6] = '{'{2'h1, 15, 1'b0, 1'b1}, '{2'h1, 30, 1'b0, 1'b1},
    '{2'h0, 10, 1'b1, 1'b1}, '{2'h0, 43, 1'b0, 1'b0},
    '{2'h2, 30, 1'b0, 1'b1}, '{2'h2, 42, 1'b1, 1'b1}};
  wakeup_watchdog_reset #(.HALF_PERIOD_CYC(HALF), .RST_DELAY_CYC(RST),
    .REL_TO_WAKE_CYC(REL)) dut_u (
    .clk(clk), .reset(reset), .in_regulation(in_regulation),
    .watchdog_input(watchdog_input), .wakeup(wakeup), .reset_out_n(reset_out_n));
  mcu_model mcu_u (.clk(clk), .wakeup(wakeup), .mode(mode), .watchdog_input(watchdog_input));
  initial
    forever #2 clk = ~clk;
  task automatic check(input logic a, input logic b);
    checked++;
    if (a !== b)
    begin
      n_fail++;
      $display("mismatch at %0t: %h expected %h", $time, a, b);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // bounded wait: low first, so a rise already past is not taken twice
  task automatic wait_rise();
    for (t = 0; t < 300 && wakeup !== 1'b0; t++) @(negedge clk);
    for (t = 0; t < 300 && wakeup !== 1'b1; t++) @(negedge clk);
  endtask
  // a run far longer than the sequence means a hang
  initial
  begin
    #40000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    reset = 1'b0;
    check(wakeup, 1'b0);
    repeat (30) @(negedge clk);
    check(reset_out_n, 1'b0);
    // rows run on the first pass; the second pass re-tests recovery alone
    for (p = 0; p < 2; p++)
    begin
      in_regulation = 1'b1;
      for (t = 0; t < 99 && reset_out_n !== 1'b1; t++) @(negedge clk);
      check(t >= RST && t <= RST + 8, 1'b1);
      for (i = 0; i < 6 * (1 - p); i++)
      begin
        mode = rows[i].m;
        wait_rise();
        repeat (rows[i].off) @(negedge clk);
        check(wakeup, rows[i].w);
        check(reset_out_n, rows[i].r);
      end
      mode = 2'h1;
      wait_rise();
      in_regulation = 1'b0;
      repeat (40) @(negedge clk);
      check(wakeup, 1'b0);
      check(reset_out_n, 1'b0);
    end
    // block reset in mid-run, just after a wake-up rise
    in_regulation = 1'b1;
    wait_rise();
    reset = 1'b1;
    repeat (2) @(negedge clk);
    check(wakeup, 1'b0);
    check(reset_out_n, 1'b0);
    reset = 1'b0;
    @(negedge clk);
    check(wakeup, 1'b0);
    check(reset_out_n, 1'b0);
    for (t = 0; t < 99 && reset_out_n !== 1'b1; t++) @(negedge clk);
    check(t >= RST && t <= RST + 8, 1'b1);
    // first rise comes exactly the release delay after reset goes high
    for (t = 0; t < 99 && wakeup !== 1'b1; t++) @(negedge clk);
    check(t == REL, 1'b1);
    stop_test();
  end
endmodule

/* File: bench/wdog_chk.sv */
// checker: timing relations at the supervisor pins
`timescale 1ns/100ps
module wdog_chk #(
  parameter int unsigned HALF_PERIOD_CYC = 20, // half wake-up period
  parameter int unsigned RST_DELAY_CYC = 5 // reset delay
)
(
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic in_regulation, // regulation flag
  input wire logic watchdog_input, // watchdog pin
  input wire logic wakeup, // wake-up out
  input wire logic reset_out_n // reset out, active low
);
  logic wake_d_r, wd_d_r, seen_r, miss_r; // delayed pins, cycle flags
  logic [31:0] cnt_r; // cycles since last rise
  logic rise; // wake-up rose
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  assign rise = wakeup && !wake_d_r;
  // flags clear while reset is high or reset_out_n is low, so a period cut by reset is never judged
  always_ff @(posedge clk)
  begin
    wake_d_r <= reset ? 1'b0 : wakeup;
    wd_d_r <= reset ? 1'b1 : watchdog_input;
    cnt_r <= (reset || rise || !reset_out_n) ? 32'h0 : cnt_r + 32'h1;
    seen_r <= (reset || !reset_out_n) ? 1'b0 : (seen_r || rise);
    miss_r <= (reset || !reset_out_n) ? 1'b0 : (rise || (miss_r && !(wd_d_r && !watchdog_input)));
  end
  sequence wake_hold_low;
    !wakeup [*8];
  endsequence
  AST_RST_WAKE: assert property (!reset_out_n [*2] |-> !wakeup)
    else $error("wake high in reset");
  AST_HOLD: assert property (!in_regulation [*8] |-> !reset_out_n)
    else $error("reset released unregulated");
  AST_REL_DELAY: assert property ($rose(reset_out_n) |-> $past(in_regulation, RST_DELAY_CYC))
    else $error("reset released early");
  AST_FIRST_RISE: assert property ($rose(reset_out_n) |-> wake_hold_low ##[1:6] wakeup)
    else $error("first rise off time");
  AST_PERIOD: assert property (rise && seen_r |-> cnt_r == 2 * HALF_PERIOD_CYC - 1)
    else $error("wake period wrong");
  AST_WD_LOW: assert property ($fell(watchdog_input) && wakeup && reset_out_n |-> ##[1:8] !wakeup)
    else $error("wake not pulled low");
  AST_MISS: assert property (miss_r && cnt_r == 2 * HALF_PERIOD_CYC - 1 |-> ##[0:7] !reset_out_n)
    else $error("no reset after miss");
  AST_REG_LOSS: assert property ($fell(in_regulation) |-> ##[1:8] !reset_out_n)
    else $error("no reset on loss");
endmodule
bind wakeup_watchdog_reset wdog_chk #(.HALF_PERIOD_CYC(HALF_PERIOD_CYC),
  .RST_DELAY_CYC(RST_DELAY_CYC)) chk_u (.clk(clk), .reset(reset), .in_regulation(in_regulation),
  .watchdog_input(watchdog_input), .wakeup(wakeup), .reset_out_n(reset_out_n));

/* File: pkg/wdog_pkg.sv */
// package: timing constants and state encoding for the wake-up watchdog supervisor
package wdog_pkg;
  // timing resistor default in ohms; all times but the clock period and the watchdog response scale from it
  localparam int TIMING_RESISTOR_OHM = 60000;
  // clock period in picoseconds (250 MHz)
  localparam longint CLK_PERIOD_PS = 64'd4000;
  // coefficients scaled to picoseconds per ohm (x1e12)
  localparam longint WAKE_PERIOD_PS_PER_OHM = 64'd417000; // 4.17e-7 s/ohm
  localparam longint RST_DELAY_PS_PER_OHM = 64'd52100; // 5.21e-8 s/ohm
  localparam longint REL_TO_WAKE_PS_PER_OHM = 64'd208000; // 2.08e-7 s/ohm
  // watchdog response time, picoseconds (2.0 us)
  localparam longint WDI_RESP_PS = 64'd2000000;
  localparam int WDI_RESP_CYC = int'(WDI_RESP_PS / CLK_PERIOD_PS);
  // derived default cycle counts at the default resistor
  localparam longint HALF_PERIOD_CYC_DEF =
    (WAKE_PERIOD_PS_PER_OHM * TIMING_RESISTOR_OHM) / (2 * CLK_PERIOD_PS);
  localparam longint RST_DELAY_CYC_DEF =
    (RST_DELAY_PS_PER_OHM * TIMING_RESISTOR_OHM + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint REL_TO_WAKE_CYC_DEF =
    (REL_TO_WAKE_PS_PER_OHM * TIMING_RESISTOR_OHM + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 32; // counter width
  localparam logic SYNC_RESET_VAL = 1'b0; // synchroniser reset value
  // supervisor states
  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001, // reset asserted, waiting for regulation
    ST_DELAY = 4'b0010, // reset delay running
    ST_PRE = 4'b0100, // reset released, waiting for first rise
    ST_RUN = 4'b1000 // wake-up cycles running
  } sup_state_t;
endpackage

/* File: rtl/pin_sync.sv */
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/100ps
module pin_sync
  import wdog_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset, // synchronous reset, active high
  input wire logic pin, // asynchronous pin
  output logic level // filtered level
);
  logic [2:0] sh_r; // sh_r[0] is the metastable stage
  logic [2:0] sh_nxt;
  logic level_r;
  logic level_nxt;

  // shift; filtered level changes only when stages two and three agree
  always_comb
  begin
    sh_nxt = {sh_r[1:0], pin};
    level_nxt = level_r;
    if (sh_r[1] == sh_r[2])
    begin
      level_nxt = sh_r[2];
    end
  end

  // register only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sh_r <= {3{SYNC_RESET_VAL}};
      level_r <= SYNC_RESET_VAL;
    end
    else
    begin
      sh_r <= sh_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule

/* File: rtl/wakeup_watchdog_reset.sv */
// wake-up generator, watchdog monitor and reset supervisor
// Behaviour
// [R1] wake-up output is continuous 50% square wave
// [R2] period, reset delay, release delay scale together
// [R3] microcontroller pulses watchdog after each wake rise
// [R4] first watchdog fall drives wake-up low
// [R5] later watchdog falls in cycle are ignored
// [R6] reset held until output is in regulation
// [R7] regulation loss resets; release after reset delay
// [R8] no watchdog fall in cycle gives reset
// [R9] wake-up forced low while reset asserted
// [R10] after release, cycle restarts after release delay
// [R11] timings are parameterised clock cycle counts
`timescale 1ns/100ps
module wakeup_watchdog_reset
  import wdog_pkg::*;
#(
  // package counts are 64-bit; cut to the 32-bit counter on purpose
  parameter int unsigned HALF_PERIOD_CYC = 32'(HALF_PERIOD_CYC_DEF), // half wake-up period
  parameter int unsigned RST_DELAY_CYC = 32'(RST_DELAY_CYC_DEF), // reset delay
  parameter int unsigned REL_TO_WAKE_CYC = 32'(REL_TO_WAKE_CYC_DEF) // release to first rise
)
(
  input wire logic clk, // 250 MHz clock
  input wire logic reset, // synchronous reset, active high
  input wire logic in_regulation, // regulator comparator: output in regulation
  input wire logic watchdog_input, // watchdog pin from microcontroller
  output logic wakeup, // wake-up square wave
  output logic reset_out_n // supervisor reset, active low
);
  logic reg_ok; // filtered regulation level
  logic wdi_lvl; // filtered watchdog level
  logic wdi_prev_r; // previous watchdog level for edge detection
  logic wdi_prev_nxt;
  logic wdi_fall; // one-cycle watchdog falling edge
  sup_state_t state_r; // supervisor state
  sup_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r; // shared timing counter
  logic [CNT_W-1:0] cnt_nxt;
  logic high_half_r; // 1 during first half of a wake-up cycle
  logic high_half_nxt;
  logic seen_r; // watchdog fall seen this cycle
  logic seen_nxt;
  logic wakeup_r; // registered wake-up output
  logic wakeup_nxt;
  logic rst_n_r; // registered reset output
  logic rst_n_nxt;

  // both pins come from outside the clock domain
  // one filter per pin, so a slow regulation edge never delays a watchdog fall
  pin_sync u_sync_reg (
    .clk(clk),
    .reset(reset),
    .pin(in_regulation),
    .level(reg_ok)
  );
  pin_sync u_sync_wdi (
    .clk(clk),
    .reset(reset),
    .pin(watchdog_input),
    .level(wdi_lvl)
  );

  // falling edge on the filtered level; response well inside 2 us
  // the previous level resets low, so the filter settling high after reset
  // is never mistaken for a watchdog fall
  assign wdi_fall = wdi_prev_r & ~wdi_lvl;

  // supervisor next state: one counter times every phase
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    high_half_nxt = high_half_r;
    seen_nxt = seen_r;
    wdi_prev_nxt = wdi_lvl;
    wakeup_nxt = wakeup_r;
    rst_n_nxt = rst_n_r;
    case (state_r)
      ST_HOLD:
      begin
        // reset stays low until regulation is reached
        rst_n_nxt = 1'b0; // [R6] [R7]
        wakeup_nxt = 1'b0; // [R9]
        cnt_nxt = '0;
        if (reg_ok)
        begin
          state_nxt = ST_DELAY;
        end
      end
      ST_DELAY:
      begin
        // reset delay counted only while regulation holds
        wakeup_nxt = 1'b0; // [R9]
        if (!reg_ok)
        begin
          state_nxt = ST_HOLD;
          cnt_nxt = '0;
        end
        else if (cnt_r >= CNT_W'(RST_DELAY_CYC - 1)) // [R7] [R11]
        begin
          state_nxt = ST_PRE;
          rst_n_nxt = 1'b1;
          cnt_nxt = '0;
        end
        else
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_PRE:
      begin
        // wait out the release-to-wake delay, then start a fresh cycle
        // reset is already released here; regulation loss pulls it low again
        wakeup_nxt = 1'b0;
        if (!reg_ok)
        begin
          state_nxt = ST_HOLD;
          rst_n_nxt = 1'b0;
          cnt_nxt = '0;
        end
        else if (cnt_r >= CNT_W'(REL_TO_WAKE_CYC - 1)) // [R10] [R2]
        begin
          state_nxt = ST_RUN;
          wakeup_nxt = 1'b1; // [R1]
          high_half_nxt = 1'b1;
          seen_nxt = 1'b0;
          cnt_nxt = '0;
        end
        else
        begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_RUN:
      begin
        if (!reg_ok)
        begin
          // regulation loss overrides everything
          state_nxt = ST_HOLD; // [R7]
          rst_n_nxt = 1'b0;
          wakeup_nxt = 1'b0; // [R9]
          cnt_nxt = '0;
        end
        else
        begin
          // the microcontroller answers each rise with a pulse
          // only the first fall of a cycle acts; later ones find seen_r set
          if (wdi_fall && !seen_r) // [R5]
          begin
            seen_nxt = 1'b1;
            wakeup_nxt = 1'b0; // [R4]
          end
          if (cnt_r >= CNT_W'(HALF_PERIOD_CYC - 1)) // [R1] [R11]
          begin
            cnt_nxt = '0;
            if (high_half_r)
            begin
              // mid-cycle: wake-up falls to give a 50% wave
              high_half_nxt = 1'b0;
              wakeup_nxt = 1'b0;
            end
            // a fall on this very edge still counts for this cycle; the later clear of seen_nxt wins over its set
            else if (!(seen_r || (wdi_fall && !seen_r)))
            begin
              // end of cycle with no watchdog fall: reset pulse
              state_nxt = ST_DELAY; // [R8]
              rst_n_nxt = 1'b0;
              wakeup_nxt = 1'b0; // [R9]
            end
            else
            begin
              // next cycle starts high; watchdog window reopens
              high_half_nxt = 1'b1;
              seen_nxt = 1'b0;
              wakeup_nxt = 1'b1; // [R1]
            end
          end
          else
          begin
            cnt_nxt = cnt_r + 1'b1;
          end
        end
      end
      default:
      begin
        state_nxt = ST_HOLD;
        rst_n_nxt = 1'b0;
        wakeup_nxt = 1'b0;
        cnt_nxt = '0;
      end
    endcase
  end

  // register only; reset enters hold with reset asserted
  // synchronous reset: the outputs can change only on a clock edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= ST_HOLD;
      cnt_r <= '0;
      high_half_r <= 1'b0;
      seen_r <= 1'b0;
      wdi_prev_r <= 1'b0;
      wakeup_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      high_half_r <= high_half_nxt;
      seen_r <= seen_nxt;
      wdi_prev_r <= wdi_prev_nxt;
      wakeup_r <= wakeup_nxt;
      rst_n_r <= rst_n_nxt;
    end
  end

  assign wakeup = wakeup_r;
  assign reset_out_n = rst_n_r;
endmodule
